// *** bench/tb_top.sv ***
// Self-checking bench for the regulator configuration bank.
// Assumes the bank and the host model above; soft-start step shortened to 4.
`timescale 1ns/1ps
`include "vrcfg_regs.svh"

module tb_top;
    localparam int unsigned STEP = 4;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, vout_code, rd;
    logic reg_wr, target_from_command_sel, loop_test_enable, overcurrent_latchoff_enable;
    logic [7:0] vout_command = 8'hA5;
    logic [7:0] vid_pins = 8'h3C;
    logic softstart_go = 1'b0;
    logic ramp_done = 1'b0;
    logic current_limit_in = 1'b0;
    logic [2:0] phase_count;
    logic latchoff, ramp_enable, ok;
    logic [10:0] slew_mv_per_ms;
    vrcfg_pkg::vrcfg_ss_t ss_interval;
    int err_count = 0;
    int total_checks = 0;
    int n, len;

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    vrcfg_host_model vrcfg_host_model_inst (.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));

    vrcfg_bank #(.DELAY_STEP_CYC(STEP)) vrcfg_bank_inst (.core_clk(core_clk), .reset(reset),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .vout_command(vout_command), .vid_pins(vid_pins),
        .softstart_go(softstart_go), .ramp_done(ramp_done), .current_limit_in(current_limit_in),
        .phase_count(phase_count), .target_from_command_sel(target_from_command_sel),
        .vout_code(vout_code), .loop_test_enable(loop_test_enable),
        .overcurrent_latchoff_enable(overcurrent_latchoff_enable), .latchoff(latchoff),
        .ss_interval(ss_interval), .ramp_enable(ramp_enable), .slew_mv_per_ms(slew_mv_per_ms));

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers: always leave the bench just after a rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        total_checks++;
        if (seen !== expv) begin
            err_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expv);
        end
    endtask

    task automatic pulse_go();
        softstart_go = 1'b1;
        tick(1);
        softstart_go = 1'b0;
    endtask

    // Waits for a state, then counts the cycles it lasts; both bounded
    task automatic measure(input vrcfg_pkg::vrcfg_ss_t st, output int cnt);
        int w;
        w = 0;
        cnt = 0;
        while (ss_interval !== st && w < 100) begin
            tick(1);
            w++;
        end
        while (ss_interval === st && cnt < 200) begin
            tick(1);
            cnt++;
        end
    endtask

    task automatic set_cfg(input logic [7:0] pri, input logic [7:0] dup);
        vrcfg_host_model_inst.write_reg(`VRCFG_CFG_PRI_ADDR, pri);
        vrcfg_host_model_inst.write_reg(`VRCFG_CFG_DUP_ADDR, dup);
        tick(3);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0] addrs [4] = '{8'hD2, 8'hD3, 8'hD4, 8'hD5};
        logic [7:0] rstv [4] = '{8'h52, 8'h52, 8'h03, 8'h02};
        logic [7:0] fullv [4] = '{8'h7E, 8'h7E, 8'h07, 8'h07};
        logic [7:0] phase_codes [4] = '{8'h00, 8'h40, 8'h20, 8'h60};
        tick(2);
        reset = 1'b0;
        // Reset values, unmapped code reads zero
        for (int i = 0; i < 4; i++) begin
            vrcfg_host_model_inst.read_reg(addrs[i], rd);
            check({8'h00, rd}, {8'h00, rstv[i]});
        end
        vrcfg_host_model_inst.read_reg(8'hD6, rd);
        check({8'h00, rd}, 16'h0000);
        // All ones written: reserved bits stay at their reset level
        for (int i = 0; i < 4; i++) begin
            vrcfg_host_model_inst.write_reg(addrs[i], 8'hFF);
            vrcfg_host_model_inst.read_reg(addrs[i], rd);
            check({8'h00, rd}, {8'h00, fullv[i]});
        end
        // Phase field decode
        for (int i = 0; i < 4; i++) begin
            set_cfg(phase_codes[i] | 8'h02, 8'h52);
            check({13'h0000, phase_count}, 16'(i + 1));
        end
        // Voltage target source, VID pins pass a two-flop sync
        set_cfg(8'h0A, 8'h52);
        check({8'h00, vout_code}, 16'h00A5);
        check({15'h0000, target_from_command_sel}, 16'h0001);
        set_cfg(8'h02, 8'h52);
        check({8'h00, vout_code}, 16'h003C);
        // Loop test needs both copies, latchoff needs either: every combination of the two
        for (int k = 0; k < 4; k++) begin
            set_cfg(k[0] ? 8'h06 : 8'h00, k[1] ? 8'h06 : 8'h00);
            check({15'h0000, loop_test_enable}, {15'h0000, k == 3});
            check({15'h0000, overcurrent_latchoff_enable}, {15'h0000, k != 0});
        end
        // Slew codes
        for (int c = 0; c < 8; c++) begin
            vrcfg_host_model_inst.write_reg(`VRCFG_SS_SLEW_ADDR, 8'(c));
            tick(2);
            check({5'h00, slew_mv_per_ms}, 16'(100 + 200 * c));
        end
        // Full soft-start sequence for every delay code
        for (int c = 0; c < 8; c++) begin
            vrcfg_host_model_inst.write_reg(`VRCFG_SS_DELAY_ADDR, 8'(c));
            tick(1);
            pulse_go();
            measure(vrcfg_pkg::soft_start_interval_one, n);
            check(16'(n), 16'((c + 1) * STEP));
            tick(1);
            check({15'h0000, ramp_enable}, 16'h0001);
            ramp_done = 1'b1;
            tick(1);
            ramp_done = 1'b0;
            measure(vrcfg_pkg::soft_start_interval_three, n);
            check(16'(n), 16'((c + 1) * STEP));
            tick(1);
            check({15'h0000, ramp_enable}, 16'h0001);
            ramp_done = 1'b1;
            tick(1);
            ramp_done = 1'b0;
            measure(vrcfg_pkg::soft_start_interval_five, n);
            check(16'(n), 16'((c + 1) * STEP));
            check(16'(ss_interval), 16'(vrcfg_pkg::ss_done));
        end
        // Latchoff timer length follows the live delay code
        set_cfg(8'h52, 8'h52);
        for (int c = 0; c < 2; c++) begin
            vrcfg_host_model_inst.write_reg(`VRCFG_SS_DELAY_ADDR, 8'(c));
            tick(2);
            len = 4 * (c + 1) * STEP;
            current_limit_in = 1'b1;
            n = 0;
            while (latchoff !== 1'b1 && n < 400) begin
                tick(1);
                n++;
            end
            ok = (n >= len + 1) && (n <= len + 5);
            check({15'h0000, ok}, 16'h0001);
            current_limit_in = 1'b0;
            pulse_go();
            tick(1);
            check({15'h0000, latchoff}, 16'h0000);
        end
        // Latchoff off in both copies: current limit may last indefinitely
        set_cfg(8'h50, 8'h50);
        current_limit_in = 1'b1;
        tick(3 * len + 10);
        check({15'h0000, latchoff}, 16'h0000);
        current_limit_in = 1'b0;
        // A write while the clock enable is low is not taken
        clk_en = 1'b0;
        vrcfg_host_model_inst.write_reg(`VRCFG_SS_SLEW_ADDR, 8'h05);
        clk_en = 1'b1;
        vrcfg_host_model_inst.read_reg(`VRCFG_SS_SLEW_ADDR, rd);
        check({8'h00, rd}, 16'h0007);
        finish_test();
    end

endmodule

// *** bench/vrcfg_host_model.sv ***
// Host side of the configuration bank: byte writes and reads by command code.
// Assumes calls start just after a rising edge of core_clk with clk_en high.
`timescale 1ns/1ps

module vrcfg_host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata
);

    // Idle bus at time zero; the address points at an unmapped code
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One write: strobe held for exactly one edge, data scrambled afterwards
    // so a stale byte can never look like a valid one; one idle edge follows
    // so a back-to-back call never re-raises the strobe in the same step
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~data;
        @(posedge core_clk);
        #1;
    endtask

    // One read: read data is registered, so it is taken one edge after the code;
    // the code is left standing so the next call assigns it only once per step
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        reg_addr = addr;
        @(posedge core_clk);
        #1;
        data = reg_rdata;
    endtask

endmodule

// *** hw/vrcfg_bank.sv ***
// Configuration bank of a multi-phase buck controller: phase count,
// voltage target source, gated test and latchoff enables, soft-start
// sequencing and the current-limit latchoff timer.
// Assumes the bus protocol engine sits on core_clk and presents one
// command code per access; vid_pins and current_limit_in are async pins.
`timescale 1ns/1ps
`include "vrcfg_regs.svh"

module vrcfg_bank #(
    parameter int unsigned DELAY_STEP_CYC = `VRCFG_DELAY_STEP_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] vout_command,
    input wire logic [7:0] vid_pins,
    input wire logic softstart_go,
    input wire logic ramp_done,
    input wire logic current_limit_in,
    output logic [2:0] phase_count,
    output logic target_from_command_sel,
    output logic [7:0] vout_code,
    output logic loop_test_enable,
    output logic overcurrent_latchoff_enable,
    output logic latchoff,
    output vrcfg_pkg::vrcfg_ss_t ss_interval,
    output logic ramp_enable,
    output logic [10:0] slew_mv_per_ms
);

    ////////////////////////////////////////////////////////////////////
    // Functions

    // Phase field to phase count; bit 4 carries no meaning
    function automatic logic [2:0] phase_decode(input logic [2:0] f);
        logic [2:0] n;
        n = 3'h1;
        case (f[2:1])
            2'b10: n = 3'h2;
            2'b01: n = 3'h3;
            2'b11: n = 3'h4;
            default: n = 3'h1;
        endcase
        return n;
    endfunction

    // Delay code to cycles: (code + 1) half-millisecond steps
    function automatic logic [23:0] delay_cycles(input logic [2:0] c);
        return 24'((32'(c) + 32'h1) * DELAY_STEP_CYC);
    endfunction

    // Rise code to mV/ms
    function automatic logic [10:0] slew_decode(input logic [2:0] c);
        return 11'(`VRCFG_SLEW_BASE + `VRCFG_SLEW_STEP * 32'(c));
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] cfg_a_q;
    logic [7:0] cfg_b_q;
    logic [2:0] delay_q;
    logic [2:0] rise_q;
    logic wr_ok;

    assign wr_ok = clk_en && reg_wr;

    // Config copies keep reserved bits at their reset value
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_a_q <= `VRCFG_CFG_RST;
            cfg_b_q <= `VRCFG_CFG_RST;
        end else if (wr_ok) begin
            if (reg_addr == `VRCFG_CFG_PRI_ADDR) begin
                cfg_a_q <= (reg_wdata & `VRCFG_CFG_WMASK) | (`VRCFG_CFG_RST & ~`VRCFG_CFG_WMASK);
            end
            if (reg_addr == `VRCFG_CFG_DUP_ADDR) begin
                cfg_b_q <= (reg_wdata & `VRCFG_CFG_WMASK) | (`VRCFG_CFG_RST & ~`VRCFG_CFG_WMASK);
            end
        end
    end

    // Code registers hold three bits only; upper bits read as reset
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            delay_q <= 3'(`VRCFG_DELAY_RST & `VRCFG_CODE_WMASK);
            rise_q <= 3'(`VRCFG_SLEW_RST & `VRCFG_CODE_WMASK);
        end else if (wr_ok) begin
            if (reg_addr == `VRCFG_SS_DELAY_ADDR) begin
                delay_q <= reg_wdata[2:0];
            end
            if (reg_addr == `VRCFG_SS_SLEW_ADDR) begin
                rise_q <= reg_wdata[2:0];
            end
        end
    end

    // Registered read; unmapped codes return zero
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            case (reg_addr)
                `VRCFG_CFG_PRI_ADDR: reg_rdata <= cfg_a_q;
                `VRCFG_CFG_DUP_ADDR: reg_rdata <= cfg_b_q;
                `VRCFG_SS_DELAY_ADDR: reg_rdata <= {5'h00, delay_q};
                `VRCFG_SS_SLEW_ADDR: reg_rdata <= {5'h00, rise_q};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [7:0] vid_s1_q;
    logic [7:0] vid_s2_q;
    logic cl_s1_q;
    logic cl_s2_q;

    // Two stages each; only the second stage feeds logic
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            vid_s1_q <= 8'h00;
            vid_s2_q <= 8'h00;
            cl_s1_q <= 1'b0;
            cl_s2_q <= 1'b0;
        end else if (clk_en) begin
            vid_s1_q <= vid_pins;
            vid_s2_q <= vid_s1_q;
            cl_s1_q <= current_limit_in;
            cl_s2_q <= cl_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Decoded configuration outputs

    // All registered, so each lags its register by one cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            phase_count <= 3'h1;
            target_from_command_sel <= 1'b0;
            vout_code <= 8'h00;
            loop_test_enable <= 1'b0;
            overcurrent_latchoff_enable <= 1'b1;
            slew_mv_per_ms <= 11'h000;
        end else if (clk_en) begin
            phase_count <= phase_decode(cfg_a_q[`VRCFG_PHASE_HI:`VRCFG_PHASE_LO]);
            target_from_command_sel <= cfg_a_q[`VRCFG_TARGET_BIT];
            vout_code <= cfg_a_q[`VRCFG_TARGET_BIT] ? vout_command : vid_s2_q;
            loop_test_enable <= cfg_a_q[`VRCFG_LOOP_BIT] & cfg_b_q[`VRCFG_LOOP_BIT];
            // A single stray clear must not defeat protection
            overcurrent_latchoff_enable <= cfg_a_q[`VRCFG_LATCH_BIT] | cfg_b_q[`VRCFG_LATCH_BIT];
            slew_mv_per_ms <= slew_decode(rise_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Soft-start sequencer

    vrcfg_pkg::vrcfg_ss_t ss_q;
    logic [23:0] ss_cnt_q;

    // Delay intervals count down a reloaded timer; ramps wait for ramp_done
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ss_q <= vrcfg_pkg::ss_idle;
            ss_cnt_q <= 24'h000000;
        end else if (clk_en) begin
            case (ss_q)
                vrcfg_pkg::ss_idle, vrcfg_pkg::ss_done: begin
                    if (softstart_go) begin
                        ss_q <= vrcfg_pkg::soft_start_interval_one;
                        ss_cnt_q <= delay_cycles(delay_q) - 24'h000001;
                    end
                end
                vrcfg_pkg::soft_start_interval_one: begin
                    if (ss_cnt_q == 24'h000000) begin
                        ss_q <= vrcfg_pkg::ss_interval_two;
                    end else begin
                        ss_cnt_q <= ss_cnt_q - 24'h000001;
                    end
                end
                vrcfg_pkg::ss_interval_two: begin
                    if (ramp_done) begin
                        ss_q <= vrcfg_pkg::soft_start_interval_three;
                        ss_cnt_q <= delay_cycles(delay_q) - 24'h000001;
                    end
                end
                vrcfg_pkg::soft_start_interval_three: begin
                    if (ss_cnt_q == 24'h000000) begin
                        ss_q <= vrcfg_pkg::soft_start_interval_four;
                    end else begin
                        ss_cnt_q <= ss_cnt_q - 24'h000001;
                    end
                end
                vrcfg_pkg::soft_start_interval_four: begin
                    if (ramp_done) begin
                        ss_q <= vrcfg_pkg::soft_start_interval_five;
                        ss_cnt_q <= delay_cycles(delay_q) - 24'h000001;
                    end
                end
                vrcfg_pkg::soft_start_interval_five: begin
                    if (ss_cnt_q == 24'h000000) begin
                        ss_q <= vrcfg_pkg::ss_done;
                    end else begin
                        ss_cnt_q <= ss_cnt_q - 24'h000001;
                    end
                end
                default: ss_q <= vrcfg_pkg::ss_idle;
            endcase
        end
    end

    // Sequencer outputs, one cycle behind the state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ss_interval <= vrcfg_pkg::ss_idle;
            ramp_enable <= 1'b0;
        end else if (clk_en) begin
            ss_interval <= ss_q;
            ramp_enable <= (ss_q == vrcfg_pkg::ss_interval_two) || (ss_q == vrcfg_pkg::soft_start_interval_four);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Current-limit latchoff timer

    logic [25:0] lim_cnt_q;
    logic [25:0] lim_len;

    // Four delays; recomputed live so a new code applies at once
    assign lim_len = 26'(`VRCFG_LATCH_MULT) * {2'b00, delay_cycles(delay_q)};

    // Counts continuous limiting; a break in limiting restarts it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lim_cnt_q <= 26'h0000000;
            latchoff <= 1'b0;
        end else if (clk_en) begin
            if (softstart_go) begin
                lim_cnt_q <= 26'h0000000;
                latchoff <= 1'b0;
            end else if (!cl_s2_q || !overcurrent_latchoff_enable || latchoff) begin
                lim_cnt_q <= 26'h0000000;
            end else if (lim_cnt_q >= lim_len - 26'h0000001) begin
                latchoff <= 1'b1;
            end else begin
                lim_cnt_q <= lim_cnt_q + 26'h0000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    phase_two_a: assert property (@(posedge core_clk) disable iff (reset)
        ($past(clk_en) && $past(cfg_a_q[6:4]) == 3'b100) |-> phase_count == 3'h2)
        else $error("phase code 100 did not give two phases");

    phase_four_a: assert property (@(posedge core_clk) disable iff (reset)
        ($past(clk_en) && $past(cfg_a_q[6:4]) == 3'b110) |-> phase_count == 3'h4)
        else $error("phase code 110 did not give four phases");

    target_source_a: assert property (@(posedge core_clk) disable iff (reset)
        ($past(clk_en) && !$past(cfg_a_q[3])) |-> vout_code == $past(vid_s2_q))
        else $error("vid pins not followed with target bit clear");

    loop_both_a: assert property (@(posedge core_clk) disable iff (reset)
        loop_test_enable |-> ($past(cfg_a_q[2]) && $past(cfg_b_q[2])))
        else $error("loop test enabled without both copies set");

    latch_both_a: assert property (@(posedge core_clk) disable iff (reset)
        !overcurrent_latchoff_enable |-> (!$past(cfg_a_q[1]) && !$past(cfg_b_q[1])))
        else $error("latchoff disabled while a copy still enables it");

    dup_gate_a: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && !cfg_b_q[2]) |=> !loop_test_enable)
        else $error("duplicate copy did not gate loop test");

    delay_load_a: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && ss_q == vrcfg_pkg::ss_idle && softstart_go)
        |=> ss_cnt_q == delay_cycles($past(delay_q)) - 24'h000001)
        else $error("soft-start delay loaded with wrong length");

    latch_time_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(latchoff) |-> $past(lim_cnt_q) == $past(lim_len) - 26'h0000001)
        else $error("latchoff fired before four delays of limiting");

    slew_value_a: assert property (@(posedge core_clk) disable iff (reset)
        ($past(clk_en) && $past(rise_q) == 3'h7) |-> slew_mv_per_ms == 11'h5DC)
        else $error("top rise code not 1.5 V/ms");

    reserved_bits_a: assert property (@(posedge core_clk) disable iff (reset)
        (cfg_a_q[7] == 1'b0) && (cfg_a_q[0] == 1'b0) && (cfg_b_q[7] == 1'b0) && (cfg_b_q[0] == 1'b0))
        else $error("reserved config bit left its reset value");

endmodule

// *** hw/vrcfg_pkg.sv ***
// Types shared by the regulator configuration bank.
// Assumes nothing of its surroundings.
package vrcfg_pkg;

    // Soft-start sequence: delays in one, three, five; ramps in two, four
    typedef enum logic [2:0] {
        ss_idle,
        soft_start_interval_one,
        ss_interval_two,
        soft_start_interval_three,
        soft_start_interval_four,
        soft_start_interval_five,
        ss_done
    } vrcfg_ss_t;

endpackage

// *** hw/vrcfg_regs.svh ***
// Offsets, field positions, reset values and timing figures of the
// regulator configuration bank.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef VRCFG_REGS_SVH
`define VRCFG_REGS_SVH

// Command codes of the four configuration registers
`define VRCFG_CFG_PRI_ADDR 8'hD2
`define VRCFG_CFG_DUP_ADDR 8'hD3
`define VRCFG_SS_DELAY_ADDR 8'hD4
`define VRCFG_SS_SLEW_ADDR 8'hD5

// Reset values
`define VRCFG_CFG_RST 8'h52
`define VRCFG_DELAY_RST 8'h03
`define VRCFG_SLEW_RST 8'h02

// Writable bits; the rest are reserved
`define VRCFG_CFG_WMASK 8'h7E
`define VRCFG_CODE_WMASK 8'h07

// Field positions of the configuration registers
`define VRCFG_PHASE_HI 6
`define VRCFG_PHASE_LO 4
`define VRCFG_TARGET_BIT 3
`define VRCFG_LOOP_BIT 2
`define VRCFG_LATCH_BIT 1

// Soft-start delay step and clock period
`define VRCFG_DELAY_STEP_NS 500000
`define VRCFG_CLK_NS 5
`define VRCFG_DELAY_STEP_CYC (`VRCFG_DELAY_STEP_NS / `VRCFG_CLK_NS)
// Latchoff timer as a multiple of the soft-start delay
`define VRCFG_LATCH_MULT 4
// Slew rate base and step in mV/ms
`define VRCFG_SLEW_BASE 100
`define VRCFG_SLEW_STEP 200

`endif
